// ---- tb/pllcal_host.sv ----
// Host model driving register writes and transfer strobes
`timescale 1ns/1ns
`include "pllcal_defs.svh"

module pllcal_host
(
    // Clock
    input  wire logic           clk_sys_in,
    // Register port
    output pllcal_pkg::pllcal_wr_t wr_out,
    output logic               io_update_out
);
    import pllcal_pkg::*;

    initial
    begin
        wr_out = '0;
        io_update_out = 1'b0;
    end

    task automatic write(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        wr_out <= '{1'b1, a, d};
        @(posedge clk_sys_in);
        wr_out.wr_en <= 1'b0;
    endtask

    task automatic strobe();
        @(posedge clk_sys_in);
        io_update_out <= 1'b1;
        @(posedge clk_sys_in);
        io_update_out <= 1'b0;
    endtask

    // ---------------------------------------------------------------
    // Calibration start, trigger made active as 0 then 1
    // ---------------------------------------------------------------
    // VCO divider lives outside this block and is never made static
    task automatic cal_seq(input logic [7:0] base);
        write(`PLLCAL_CTRL_ADDR, base & 8'hFE);
        strobe();
        write(`PLLCAL_CTRL_ADDR, base | 8'h01);
        strobe();
    endtask
endmodule

// ---- tb/test_pllcal_ctrl.sv ----
// Self-checking testbench for the lock detect and calibration control
`timescale 1ns/1ns
`include "pllcal_defs.svh"

module test_pllcal_ctrl;
    import pllcal_pkg::*;

    logic          clk_sys_in;
    logic          nrst_in;
    logic          ref_tick;
    pllcal_wr_t    wr;
    logic          io_update;
    logic [7:0]    rd_data;
    pllcal_pfd_t   pfd;
    logic          lock;
    logic          dc;
    logic          cal_clk;
    logic          cal_start;
    int            bad_count;
    int            cmp_count;

    pllcal_ctrl u_pllcal_ctrl (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .wr_in(wr), .io_update_in(io_update), .rd_data_out(rd_data),
        .pfd_in(pfd), .ref_tick_in(ref_tick),
        .digital_lock_flag_out(lock), .cmos_dc_offset_en_out(dc),
        .cal_clk_out(cal_clk), .cal_start_out(cal_start));
    pllcal_host u_pllcal_host (.clk_sys_in(clk_sys_in), .wr_out(wr),
        .io_update_out(io_update));

    function automatic logic [7:0] cfg(input logic [1:0] cnt,
        input logic rng, input logic dis, input logic [1:0] div);
        return {1'b0, cnt, rng, dis, div, 1'b0};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // Disable then re-enable so the run count starts clean
    task automatic setup(input logic [1:0] code, input logic rng);
        u_pllcal_host.write(`PLLCAL_CTRL_ADDR, cfg(code, rng, 1'b1, 2'h3));
        u_pllcal_host.strobe();
        repeat (2) @(negedge clk_sys_in);
        check(lock, 1'b0);
        u_pllcal_host.write(`PLLCAL_CTRL_ADDR, cfg(code, rng, 1'b0, 2'h3));
        u_pllcal_host.strobe();
    endtask

    task automatic pulse(input int n, input logic [15:0] d);
        repeat (n) @(posedge clk_sys_in) pfd <= '{1'b1, d};
        @(posedge clk_sys_in) pfd <= '0;
        @(negedge clk_sys_in);
    endtask

    task automatic t_regs();
        check(rd_data, `PLLCAL_CTRL_RESET);
        check(dc, 1'b0);
        u_pllcal_host.write(10'h019, 8'h55);
        @(negedge clk_sys_in);
        check(rd_data, `PLLCAL_CTRL_RESET);
        u_pllcal_host.write(`PLLCAL_CTRL_ADDR, 8'h86);
        @(negedge clk_sys_in);
        check(rd_data, 8'h86);
        check(dc, 1'b0);
        u_pllcal_host.strobe();
        @(negedge clk_sys_in);
        check(dc, 1'b1);
    endtask

    task automatic t_cal();
        u_pllcal_host.write(`PLLCAL_CTRL_ADDR, 8'h07);
        @(negedge clk_sys_in);
        check(cal_start, 1'b0);
        u_pllcal_host.cal_seq(8'h06);
        @(negedge clk_sys_in);
        check(cal_start, 1'b1);
        @(negedge clk_sys_in);
        check(cal_start, 1'b0);
        u_pllcal_host.strobe();
        @(negedge clk_sys_in);
        check(cal_start, 1'b0);
    endtask

    task automatic t_lock(input logic [1:0] code, input int need);
        setup(code, 1'b0);
        pulse(need - 1, `PLLCAL_WIN_LO_PS - 16'h1);
        check(lock, 1'b0);
        pulse(1, `PLLCAL_WIN_LO_PS);
        check(lock, 1'b0);
        pulse(need - 1, `PLLCAL_WIN_LO_PS - 16'h1);
        check(lock, 1'b0);
        pulse(1, `PLLCAL_WIN_LO_PS - 16'h1);
        check(lock, 1'b1);
        pulse(1, `PLLCAL_LOSS_LO_PS);
        check(lock, 1'b1);
    endtask

    task automatic t_range();
        pulse(1, `PLLCAL_LOSS_LO_PS + 16'h1);
        @(negedge clk_sys_in);
        check(lock, 1'b0);
        setup(2'h0, 1'b1);
        pulse(5, `PLLCAL_WIN_HI_PS - 16'h1);
        check(lock, 1'b1);
        pulse(1, `PLLCAL_LOSS_HI_PS);
        check(lock, 1'b1);
        pulse(1, `PLLCAL_LOSS_HI_PS + 16'h1);
        @(negedge clk_sys_in);
        check(lock, 1'b0);
    endtask

    task automatic t_div();
        int  n;
        logic p;
        @(posedge clk_sys_in) ref_tick <= 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            u_pllcal_host.write(`PLLCAL_CTRL_ADDR,
                cfg(2'h0, 1'b0, 1'b0, 2'(c)));
            u_pllcal_host.strobe();
            @(negedge clk_sys_in);
            n = 0;
            for (int k = 0; k < 3; k++)
            begin
                // First run starts mid-level; later runs are full levels
                p = cal_clk;
                n = 0;
                while (cal_clk === p && n < 40)
                begin
                    @(negedge clk_sys_in);
                    n++;
                end
            end
            check(16'(n), 16'(1 << c));
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end

    // Watchdog sized well above the whole sequence
    initial
    begin
        #200000;
        bad_count++;
        final_report();
    end

    initial
    begin
        bad_count = 0;
        cmp_count = 0;
        nrst_in = 1'b0;
        ref_tick = 1'b0;
        pfd = '0;
        repeat (16) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        @(negedge clk_sys_in);
        check(lock, 1'b0);
        check(cal_start, 1'b0);
        t_regs();
        t_cal();
        t_lock(2'h0, 5);
        t_lock(2'h1, 16);
        t_lock(2'h2, 64);
        t_lock(2'h3, 255);
        t_range();
        t_div();
        final_report();
    end
endmodule

// ---- verilog/pllcal_cal_div.sv ----
// Calibration clock divider running on reference clock ticks
`timescale 1ns/1ns
`include "pllcal_defs.svh"

module pllcal_cal_div
(
    // Clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       nrst_in,
    // Reference tick and ratio
    input  wire logic       ref_tick_in,
    input  wire logic [1:0] div_sel_in,
    // Divided clock
    output logic            cal_clk_out
);
    import pllcal_pkg::*;

    pllcal_div_state_t s_q;
    pllcal_div_state_t s_d;

    // Half period minus one for each ratio code
    function automatic logic [2:0] half_last(input logic [1:0] sel);
        unique case (sel)
            2'h0: half_last = `PLLCAL_HALF_DIV2;
            2'h1: half_last = `PLLCAL_HALF_DIV4;
            2'h2: half_last = `PLLCAL_HALF_DIV8;
            2'h3: half_last = `PLLCAL_HALF_DIV16;
        endcase
    endfunction

    // -------------------------------------------------------------------
    // Divider
    // -------------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        if (ref_tick_in)
        begin
            // Ratio change applies to the half period in progress, whose count is compared to the new ratio
            if (s_q.cnt >= half_last(div_sel_in)) // R7 R8 R9
            begin
                s_d.cnt     = 3'h0;
                s_d.clk_lvl = ~s_q.clk_lvl;
            end
            else
            begin
                s_d.cnt = s_q.cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign cal_clk_out = s_q.clk_lvl;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    div_toggle_a: assert property ( // R8
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (ref_tick_in && s_q.cnt < half_last(div_sel_in))
        |=> $stable(cal_clk_out))
        else $error("Calibration clock toggled early");

    div_edge_a: assert property ( // R9
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (ref_tick_in && s_q.cnt >= half_last(div_sel_in))
        |=> cal_clk_out != $past(cal_clk_out))
        else $error("Calibration clock missed its edge");

endmodule

// ---- verilog/pllcal_ctrl.sv ----
// PLL lock detector and VCO calibration control register logic
`timescale 1ns/1ns
`include "pllcal_defs.svh"

// Function
// (R1) Lock flag sets after programmed run of consecutive in-window cycles.
// (R2) Count codes 00..11 need 5, 16, 64 or 255 cycles.
// (R3) A cycle is in-window when edge gap is below window.
// (R4) Set flag holds until gap exceeds loss-of-lock threshold.
// (R5) Bit 4 picks one of two window ranges; default 3.5 ns.
// (R6) Bit 3 set disables lock detection; default enabled.
// (R7) Calibration clock is reference clock divided by selectable ratio.
// (R8) Divider codes 00, 01, 10 give divide by 2, 4, 8.
// (R9) Divider code 11 gives divide by 16, the reset default.
// (R10) Software keeps small ratios for slow detector rates only.
// (R11) Calibration starts only on active trigger bit going 0 to 1.
// (R12) Software writes 0 then 1, each followed by transfer strobe.
// (R13) Software keeps VCO divider non-static during calibration.
// (R14) Bit 7 enables dc offset on CMOS reference input; default off.
// (R15) Out-of-window cycle before lock restarts the run count.
// (R16) Writes reach active fields only on register transfer strobe.
module pllcal_ctrl
(
    // Clock and reset
    input  wire logic               clk_sys_in,
    input  wire logic               nrst_in,
    // Serial port register access
    input  pllcal_pkg::pllcal_wr_t  wr_in,
    input  wire logic               io_update_in,
    output logic [7:0]              rd_data_out,
    // Phase detector and reference
    input  pllcal_pkg::pllcal_pfd_t pfd_in,
    input  wire logic               ref_tick_in,
    // Controls to the analog side
    output logic                    digital_lock_flag_out,
    output logic                    cmos_dc_offset_en_out,
    output logic                    cal_clk_out,
    output logic                    cal_start_out
);
    import pllcal_pkg::*;

    pllcal_state_t s_q;
    pllcal_state_t s_d;
    logic          in_win;
    logic          past_loss;
    logic [7:0]    need;

    // Consecutive cycles needed for lock
    function automatic logic [7:0] lock_need(input logic [1:0] sel);
        unique case (sel)
            2'h0: lock_need = `PLLCAL_NEED_00;
            2'h1: lock_need = `PLLCAL_NEED_01;
            2'h2: lock_need = `PLLCAL_NEED_10;
            2'h3: lock_need = `PLLCAL_NEED_11;
        endcase
    endfunction

    // -------------------------------------------------------------------
    // Window compare
    // -------------------------------------------------------------------
    always_comb
    begin
        need   = lock_need(s_q.act_reg.lock_cnt_sel);
        in_win = s_q.act_reg.win_range
               ? (pfd_in.diff_ps < `PLLCAL_WIN_HI_PS)
               : (pfd_in.diff_ps < `PLLCAL_WIN_LO_PS); // R3 R5
        // Separate, wider threshold gives unlock hysteresis
        past_loss = s_q.act_reg.win_range
               ? (pfd_in.diff_ps > `PLLCAL_LOSS_HI_PS)
               : (pfd_in.diff_ps > `PLLCAL_LOSS_LO_PS); // R4
    end

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    always_comb
    begin
        s_d           = s_q;
        s_d.cal_start = 1'b0;
        if (wr_in.wr_en && wr_in.addr == `PLLCAL_CTRL_ADDR)
            s_d.buf_reg = pllcal_ctrl_t'(wr_in.data);
        if (io_update_in)
        begin
            // Buffered value becomes active only here
            s_d.act_reg   = s_q.buf_reg; // R16 R12
            s_d.cal_start = s_q.buf_reg.cal_now
                          & ~s_q.act_reg.cal_now; // R11
        end
        if (s_q.act_reg.lock_dis)
        begin
            s_d.lock    = 1'b0; // R6
            s_d.run_cnt = 8'h00;
        end
        else if (pfd_in.cycle)
        begin
            if (s_q.lock)
            begin
                if (past_loss)
                    s_d.lock = 1'b0; // R4
            end
            else if (!in_win)
            begin
                s_d.run_cnt = 8'h00; // R15
            end
            else if (s_q.run_cnt + 8'h01 >= need)
            begin
                s_d.lock    = 1'b1; // R1 R2
                s_d.run_cnt = 8'h00;
            end
            else
            begin
                s_d.run_cnt = s_q.run_cnt + 8'h01; // R1
            end
        end
        s_d.rd_data = s_d.buf_reg;
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            s_q         <= '0;
            s_q.buf_reg <= pllcal_ctrl_t'(`PLLCAL_CTRL_RESET);
            s_q.act_reg <= pllcal_ctrl_t'(`PLLCAL_CTRL_RESET);
            s_q.rd_data <= `PLLCAL_CTRL_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // -------------------------------------------------------------------
    // Calibration clock divider
    // -------------------------------------------------------------------
    pllcal_cal_div u_cal_div
    (
        .clk_sys_in  (clk_sys_in),
        .nrst_in     (nrst_in),
        .ref_tick_in (ref_tick_in),
        .div_sel_in  (s_q.act_reg.cal_div_sel), // R7
        .cal_clk_out (cal_clk_out)
    );

    assign rd_data_out           = s_q.rd_data;
    assign digital_lock_flag_out = s_q.lock;
    assign cmos_dc_offset_en_out = s_q.act_reg.cmos_dc_en; // R14
    assign cal_start_out         = s_q.cal_start;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    sequence good_last_cycle;
        pfd_in.cycle && in_win && !s_q.act_reg.lock_dis
            && s_q.run_cnt == need - 8'h01;
    endsequence

    lock_rise_a: assert property ( // R1
        @(posedge clk_sys_in) disable iff (!nrst_in)
        $rose(digital_lock_flag_out) |-> $past(
            pfd_in.cycle && in_win && s_q.run_cnt + 8'h01 >= need))
        else $error("Lock set without full in-window run");

    lock_count_a: assert property ( // R2
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (!s_q.lock && !io_update_in) ##0 good_last_cycle
        |=> digital_lock_flag_out)
        else $error("Lock not set at required count");

    count_step_a: assert property ( // R3
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (!s_q.lock && pfd_in.cycle && in_win && !s_q.act_reg.lock_dis
            && s_q.run_cnt + 8'h01 < need)
        |=> s_q.run_cnt == $past(s_q.run_cnt) + 8'h01)
        else $error("In-window cycle not counted");

    lock_hold_a: assert property ( // R4
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (s_q.lock && !past_loss && !s_q.act_reg.lock_dis)
        |=> digital_lock_flag_out)
        else $error("Lock dropped inside hysteresis");

    det_off_a: assert property ( // R6
        @(posedge clk_sys_in) disable iff (!nrst_in)
        s_q.act_reg.lock_dis |=> !digital_lock_flag_out
            && s_q.run_cnt == 8'h00)
        else $error("Disabled detector shows lock");

    run_reset_a: assert property ( // R15
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (!s_q.lock && pfd_in.cycle && !in_win) |=> s_q.run_cnt == 8'h00)
        else $error("Run count not restarted");

    cal_edge_a: assert property ( // R11
        @(posedge clk_sys_in) disable iff (!nrst_in)
        cal_start_out |-> $past(io_update_in)
            && s_q.act_reg.cal_now && !$past(s_q.act_reg.cal_now))
        else $error("Calibration start without 0 to 1");

    active_hold_a: assert property ( // R16
        @(posedge clk_sys_in) disable iff (!nrst_in)
        !io_update_in |=> $stable(s_q.act_reg))
        else $error("Active fields changed without strobe");

    dc_offset_a: assert property ( // R14
        @(posedge clk_sys_in) disable iff (!nrst_in)
        io_update_in |=> cmos_dc_offset_en_out
            == $past(s_q.buf_reg.cmos_dc_en))
        else $error("Offset enable not from active bit");

    // Exact window edge must not count in the narrow range
    narrow_window_a: assert property ( // R5
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (!s_q.lock && pfd_in.cycle && !s_q.act_reg.lock_dis
            && !s_q.act_reg.win_range
            && pfd_in.diff_ps >= `PLLCAL_WIN_LO_PS)
        |=> !digital_lock_flag_out && s_q.run_cnt == 8'h00)
        else $error("Narrow window accepted wide gap");

    lock_loss_a: assert property ( // R4
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (s_q.lock && pfd_in.cycle && past_loss)
        |=> !digital_lock_flag_out)
        else $error("Lock kept past loss threshold");

endmodule

// ---- verilog/pllcal_defs.svh ----
// Constants for the PLL lock detect and VCO calibration control block
`ifndef PLLCAL_DEFS_SVH
`define PLLCAL_DEFS_SVH

// -----------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------
`define PLLCAL_ADDR_W        10
`define PLLCAL_CTRL_ADDR     10'h018
`define PLLCAL_CTRL_RESET    8'h06

// -----------------------------------------------------------------------
// Lock counter targets
// -----------------------------------------------------------------------
`define PLLCAL_NEED_00       8'h05
`define PLLCAL_NEED_01       8'h10
`define PLLCAL_NEED_10       8'h40
`define PLLCAL_NEED_11       8'hFF

// -----------------------------------------------------------------------
// Lock windows and loss-of-lock thresholds, in ps
// -----------------------------------------------------------------------
`define PLLCAL_WIN_LO_PS     16'h0DAC
`define PLLCAL_WIN_HI_PS     16'h1B58
`define PLLCAL_LOSS_LO_PS    16'h1B58
`define PLLCAL_LOSS_HI_PS    16'h36B0

// -----------------------------------------------------------------------
// Calibration divider half periods minus one, in reference ticks
// -----------------------------------------------------------------------
`define PLLCAL_HALF_DIV2     3'h0
`define PLLCAL_HALF_DIV4     3'h1
`define PLLCAL_HALF_DIV8     3'h3
`define PLLCAL_HALF_DIV16    3'h7

`endif

// ---- verilog/pllcal_pkg.sv ----
// Types for the PLL lock detect and VCO calibration control block
package pllcal_pkg;

    // Control register fields, msb first
    typedef struct packed {
        logic       cmos_dc_en;
        logic [1:0] lock_cnt_sel;
        logic       win_range;
        logic       lock_dis;
        logic [1:0] cal_div_sel;
        logic       cal_now;
    } pllcal_ctrl_t;

    // One phase-detector cycle report
    typedef struct packed {
        logic        cycle;
        logic [15:0] diff_ps;
    } pllcal_pfd_t;

    // Register write port
    typedef struct packed {
        logic       wr_en;
        logic [9:0] addr;
        logic [7:0] data;
    } pllcal_wr_t;

    // Main block state
    typedef struct packed {
        pllcal_ctrl_t buf_reg;
        pllcal_ctrl_t act_reg;
        logic [7:0]   run_cnt;
        logic         lock;
        logic         cal_start;
        logic [7:0]   rd_data;
    } pllcal_state_t;

    // Divider state
    typedef struct packed {
        logic [2:0] cnt;
        logic       clk_lvl;
    } pllcal_div_state_t;

endpackage
